/* File: pkg/pmcr_consts.vh */
// Register indices, field positions, reset values and clock figures
// for the port option and miscellaneous control register bank.
// Included by bare name; holds definitions only.
`ifndef PMCR_CONSTS_VH
`define PMCR_CONSTS_VH

// Register indices; byte address is four times the index
`define PMCR_IDX_PA_DATA    7'h00
`define PMCR_IDX_PA_DIR     7'h01
`define PMCR_IDX_PA_OPT     7'h02
`define PMCR_IDX_PB_DATA    7'h03
`define PMCR_IDX_PB_DIR     7'h04
`define PMCR_IDX_UNUSED     7'h05
`define PMCR_IDX_PC_DATA    7'h06
`define PMCR_IDX_PC_DIR     7'h07
`define PMCR_IDX_PC_OPT     7'h08
`define PMCR_IDX_PD_DATA    7'h09
`define PMCR_IDX_PD_DIR     7'h0A
`define PMCR_IDX_PD_OPT     7'h0B
`define PMCR_IDX_PE_DATA    7'h0C
`define PMCR_IDX_PE_DIR     7'h0D
`define PMCR_IDX_PE_OPT     7'h0E
`define PMCR_IDX_PF_DATA    7'h0F
`define PMCR_IDX_PF_DIR     7'h10
`define PMCR_IDX_SENSE_CLK  7'h49
`define PMCR_IDX_PWR_GATE   7'h4A
`define PMCR_IDX_HALT_PWM   7'h4C

// Reset value of every register
`define PMCR_RST_BYTE       8'h00

// Fields of irq_sense_clock_config
`define PMCR_SENSE_A_LSB    6
`define PMCR_CLK_OUT_BIT    5
`define PMCR_SENSE_D_LSB    3
`define PMCR_PRE_SEL_LSB    1
`define PMCR_PRE_EN_BIT     0

// Fields of peripheral_power_gate and halt_sense_pwm_config
`define PMCR_PWR_MASK       8'h1F
`define PMCR_WDG_POLICY_BIT 7
`define PMCR_SENSE_C_LSB    2
`define PMCR_PULSE1_BIT     1
`define PMCR_PULSE0_BIT     0

// Sensitivity encodings
`define PMCR_SENSE_LOW      2'h0
`define PMCR_SENSE_RISE     2'h1
`define PMCR_SENSE_FALL     2'h2
`define PMCR_SENSE_BOTH     2'h3

// CPU clock in kHz, stand-alone (12 MHz osc) and USB (48 MHz PLL)
`define PMCR_SA_DEFAULT_KHZ  16'h0BB8
`define PMCR_SA_CODE0_KHZ    16'h1770
`define PMCR_SA_CODE2_KHZ    16'h05DC
`define PMCR_SA_CODE1_KHZ    16'h02EE
`define PMCR_SA_CODE3_KHZ    16'h0177
`define PMCR_USB_DEFAULT_KHZ 16'h1770
`define PMCR_USB_CODE0_KHZ   16'h1F40
`define PMCR_USB_CODE2_KHZ   16'h07D0
`define PMCR_USB_CODE1_KHZ   16'h03E8
`define PMCR_USB_CODE3_KHZ   16'h00FA

// AXI responses
`define PMCR_RESP_OKAY      2'h0
`define PMCR_RESP_SLVERR    2'h2

`endif

/* File: rtl/pmcr_irq_sense.v */
// Edge/level detector for one external interrupt group of eight pins.
// Assumes pins are synchronous to CLOCK and enables come from registers.
module pmcr_irq_sense (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [7:0] pins,
  input  wire [7:0] enable,
  input  wire [1:0] mode,
  output reg        irq
);
`include "pmcr_consts.vh"

  reg  [7:0] prev_q;
  wire       any_rise;
  wire       any_fall;
  wire       any_low;
  reg        irq_d;

  // Per-pin events, masked by the interrupt enables
  assign any_rise = |(enable & pins & ~prev_q);
  assign any_fall = |(enable & ~pins & prev_q);
  assign any_low  = |(enable & ~pins);

  // Sensitivity select; level mode keeps requesting while low
  always @* begin
    case (mode)
      `PMCR_SENSE_LOW:  irq_d = any_fall | any_low;
      `PMCR_SENSE_RISE: irq_d = any_rise;
      `PMCR_SENSE_FALL: irq_d = any_fall;
      `PMCR_SENSE_BOTH: irq_d = any_rise | any_fall;
      default:          irq_d = 1'b0;
    endcase
  end

  // Pin history and registered request
  always @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= 8'hFF;
      irq    <= 1'b0;
    end else begin
      prev_q <= pins;
      irq    <= irq_d;
    end
  end

endmodule

/* File: rtl/pmcr_pin_cfg.v */
// Pad control for one eight-pin port: drive, enable and interrupt mask.
// Assumes data, direction and option bytes come from the register bank.
module pmcr_pin_cfg #(
  parameter HAS_OPT = 1,
  parameter IRQ_CAP = 1
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [7:0] latch,
  input  wire [7:0] dir,
  input  wire [7:0] opt,
  output reg  [7:0] pad_out,
  output reg  [7:0] pad_oe,
  output wire [7:0] irq_en
);

  wire [7:0] push_pull;
  wire [7:0] oe_d;

  // Without option bits the direction alone decides: push-pull
  assign push_pull = (HAS_OPT != 0) ? opt : 8'hFF;
  // Open drain only drives a low level; the high side stays off
  assign oe_d = dir & (push_pull | ~latch);
  // Interrupt capability on input pins with option set
  assign irq_en = (IRQ_CAP != 0) ? (~dir & opt) : 8'h00;

  // Registered pad drive
  always @(posedge clk) begin
    if (!rst_n) begin
      pad_out <= 8'h00;
      pad_oe  <= 8'h00;
    end else begin
      pad_out <= latch;
      pad_oe  <= oe_d;
    end
  end

endmodule

/* File: rtl/pmcr_top.v */
// Port option and miscellaneous control register bank, AXI4-Lite slave.
// Assumes one clock, synchronous active-low reset, synchronous pin inputs.
//
// Overview of operation
// - Input pin option 0 floating, 1 floating with interrupt on A, C, D.
// - Output pin option 0 open drain, 1 push-pull.
// - Only ports A, C, D, E have options; elsewhere direction decides.
// - All port registers reset to zero; index 5 is unused.
// - Bits 7:6 of first misc register set port A sensitivity.
// - Bits 4:3 of first misc register set port D sensitivity.
// - Bits 3:2 of third misc register set port C sensitivity.
// - Port A and D sensitivity writes need both interrupt mask bits set.
// - Bit 5 of first misc register routes CPU clock to its pin.
// - Prescaler off gives default clock, 3 MHz or 6 MHz.
// - Stand-alone prescaler codes give 6, 1.5, 0.75, 0.375 MHz.
// - USB prescaler codes give 8, 2, 1, 0.25 MHz.
// - Stand-alone at 6 MHz blocks core access to USB buffer.
// - Prescaler changes never alter the transfer coprocessor clock.
// - Power-gating bit 1 switches peripheral off, contents frozen.
// - Gating bits map PWM, timer, I2C, USB, coprocessor from bit 0.
// - Reserved bits of second and third misc registers read zero.
// - Halt policy 0 resets on HALT with watchdog active; 1 halts.
// - HALT during USB suspend never causes a watchdog reset.
// - Bits 1 and 0 of third misc register enable pulse outputs.
// - Data writes always update the latch, even for input pins.
// - Direction bit 0 selects input, 1 selects output.
module pmcr_top #(
  parameter ADDR_W = 9
) (
  input  wire              CLOCK,
  input  wire              RESETN,
  input  wire [ADDR_W-1:0] AWADDR,
  input  wire [2:0]        AWPROT,
  input  wire              AWVALID,
  output wire              AWREADY,
  input  wire [31:0]       WDATA,
  input  wire [3:0]        WSTRB,
  input  wire              WVALID,
  output wire              WREADY,
  output reg  [1:0]        BRESP,
  output reg               BVALID,
  input  wire              BREADY,
  input  wire [ADDR_W-1:0] ARADDR,
  input  wire [2:0]        ARPROT,
  input  wire              ARVALID,
  output wire              ARREADY,
  output reg  [31:0]       RDATA,
  output reg  [1:0]        RRESP,
  output reg               RVALID,
  input  wire              RREADY,
  input  wire [47:0]       PIN_IN,
  output wire [47:0]       PIN_OUT,
  output wire [47:0]       PIN_OE,
  input  wire              IRQ_MASK_HIGH,
  input  wire              IRQ_MASK_LOW,
  output wire              EXT_IRQ_A,
  output wire              EXT_IRQ_D,
  output wire              EXT_IRQ_C,
  output reg               CLOCK_OUT_EN,
  output reg               PULSE0_OUT_EN,
  output reg               PULSE1_OUT_EN,
  input  wire              USB_MODE,
  output reg  [2:0]        CPU_CLK_SEL,
  output reg  [15:0]       CPU_CLK_KHZ,
  output reg               USB_BUF_ACCESS_EN,
  output reg  [4:0]        PERIPH_OFF,
  input  wire              HALT_EXEC,
  input  wire              WATCHDOG_ACTIVE,
  input  wire              USB_SUSPEND,
  output reg               WDG_RESET_REQ,
  output reg               HALT_ENTER
);
`include "pmcr_consts.vh"

  ////////////////////////////////////////////////////////////////////
  // Functions

  // True for every register index that is implemented
  function reg_hit;
    input [6:0] idx;
    begin
      reg_hit = (idx <= `PMCR_IDX_PF_DIR && idx != `PMCR_IDX_UNUSED) ||
                idx == `PMCR_IDX_SENSE_CLK ||
                idx == `PMCR_IDX_PWR_GATE ||
                idx == `PMCR_IDX_HALT_PWM;
    end
  endfunction

  // Data read: latch on output pins, pin level on input pins
  function [7:0] pin_read;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] pin;
    begin
      pin_read = (dir & latch) | (~dir & pin);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Register state; ports packed A=0 .. F=5, eight bits each

  reg [47:0]       data_q;
  reg [47:0]       dir_q;
  reg [47:0]       opt_q;
  reg [1:0]        sense_a_q;
  reg [1:0]        sense_d_q;
  reg [1:0]        sense_c_q;
  reg              clk_out_q;
  reg [1:0]        pre_sel_q;
  reg              pre_en_q;
  reg [4:0]        pwr_off_q;
  reg              wdg_policy_q;
  reg              pulse1_q;
  reg              pulse0_q;

  // AXI holding state
  reg              aw_held_q;
  reg              w_held_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg [7:0]        wbyte_q;
  reg              wlane_q;

  wire             wr_fire;
  wire [6:0]       wr_idx;
  wire [6:0]       rd_idx;
  wire             level3;
  reg  [7:0]       rd_byte;
  wire [23:0]      irq_en;
  wire [47:0]      port_irq_en;

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshakes

  // Address and data are taken independently, in either order
  assign AWREADY = !aw_held_q && !BVALID;
  assign WREADY  = !w_held_q && !BVALID;
  assign ARREADY = !RVALID;
  // Write happens once both halves are held
  assign wr_fire = aw_held_q && w_held_q && !BVALID;
  assign wr_idx  = awaddr_q[8:2];
  assign rd_idx  = ARADDR[8:2];
  // Interrupt level 3: both mask bits set
  assign level3  = IRQ_MASK_HIGH & IRQ_MASK_LOW;

  // Write channel capture and response
  always @(posedge CLOCK) begin
    if (!RESETN) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= {ADDR_W{1'b0}};
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
      BVALID    <= 1'b0;
      BRESP     <= `PMCR_RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held_q <= 1'b1;
        wbyte_q  <= WDATA[7:0];
        wlane_q  <= WSTRB[0];
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        BVALID    <= 1'b1;
        BRESP     <= reg_hit(wr_idx) ? `PMCR_RESP_OKAY : `PMCR_RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register writes; only byte lane 0 carries register data

  always @(posedge CLOCK) begin
    if (!RESETN) begin
      data_q       <= {6{`PMCR_RST_BYTE}};
      dir_q        <= {6{`PMCR_RST_BYTE}};
      opt_q        <= {6{`PMCR_RST_BYTE}};
      sense_a_q    <= 2'h0;
      sense_d_q    <= 2'h0;
      sense_c_q    <= 2'h0;
      clk_out_q    <= 1'b0;
      pre_sel_q    <= 2'h0;
      pre_en_q     <= 1'b0;
      pwr_off_q    <= 5'h00;
      wdg_policy_q <= 1'b0;
      pulse1_q     <= 1'b0;
      pulse0_q     <= 1'b0;
    end else if (wr_fire && wlane_q) begin
      case (wr_idx)
        `PMCR_IDX_PA_DATA: data_q[7:0]   <= wbyte_q;
        `PMCR_IDX_PA_DIR:  dir_q[7:0]    <= wbyte_q;
        `PMCR_IDX_PA_OPT:  opt_q[7:0]    <= wbyte_q;
        `PMCR_IDX_PB_DATA: data_q[15:8]  <= wbyte_q;
        `PMCR_IDX_PB_DIR:  dir_q[15:8]   <= wbyte_q;
        `PMCR_IDX_PC_DATA: data_q[23:16] <= wbyte_q;
        `PMCR_IDX_PC_DIR:  dir_q[23:16]  <= wbyte_q;
        `PMCR_IDX_PC_OPT:  opt_q[23:16]  <= wbyte_q;
        `PMCR_IDX_PD_DATA: data_q[31:24] <= wbyte_q;
        `PMCR_IDX_PD_DIR:  dir_q[31:24]  <= wbyte_q;
        `PMCR_IDX_PD_OPT:  opt_q[31:24]  <= wbyte_q;
        `PMCR_IDX_PE_DATA: data_q[39:32] <= wbyte_q;
        `PMCR_IDX_PE_DIR:  dir_q[39:32]  <= wbyte_q;
        `PMCR_IDX_PE_OPT:  opt_q[39:32]  <= wbyte_q;
        `PMCR_IDX_PF_DATA: data_q[47:40] <= wbyte_q;
        `PMCR_IDX_PF_DIR:  dir_q[47:40]  <= wbyte_q;
        `PMCR_IDX_SENSE_CLK: begin
          // Sensitivity bits are locked outside interrupt level 3
          if (level3) begin
            sense_a_q <= wbyte_q[`PMCR_SENSE_A_LSB +: 2];
            sense_d_q <= wbyte_q[`PMCR_SENSE_D_LSB +: 2];
          end
          clk_out_q <= wbyte_q[`PMCR_CLK_OUT_BIT];
          pre_sel_q <= wbyte_q[`PMCR_PRE_SEL_LSB +: 2];
          pre_en_q  <= wbyte_q[`PMCR_PRE_EN_BIT];
        end
        `PMCR_IDX_PWR_GATE: begin
          pwr_off_q <= wbyte_q[4:0];
        end
        `PMCR_IDX_HALT_PWM: begin
          // Port C field is not gated; software keeps to level 3
          wdg_policy_q <= wbyte_q[`PMCR_WDG_POLICY_BIT];
          sense_c_q    <= wbyte_q[`PMCR_SENSE_C_LSB +: 2];
          pulse1_q     <= wbyte_q[`PMCR_PULSE1_BIT];
          pulse0_q     <= wbyte_q[`PMCR_PULSE0_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register reads

  // Read mux; reserved bits and unmapped indices return zero
  always @* begin
    case (rd_idx)
      `PMCR_IDX_PA_DATA: rd_byte = pin_read(dir_q[7:0], data_q[7:0], PIN_IN[7:0]);
      `PMCR_IDX_PA_DIR:  rd_byte = dir_q[7:0];
      `PMCR_IDX_PA_OPT:  rd_byte = opt_q[7:0];
      `PMCR_IDX_PB_DATA: rd_byte = pin_read(dir_q[15:8], data_q[15:8], PIN_IN[15:8]);
      `PMCR_IDX_PB_DIR:  rd_byte = dir_q[15:8];
      `PMCR_IDX_PC_DATA: rd_byte = pin_read(dir_q[23:16], data_q[23:16], PIN_IN[23:16]);
      `PMCR_IDX_PC_DIR:  rd_byte = dir_q[23:16];
      `PMCR_IDX_PC_OPT:  rd_byte = opt_q[23:16];
      `PMCR_IDX_PD_DATA: rd_byte = pin_read(dir_q[31:24], data_q[31:24], PIN_IN[31:24]);
      `PMCR_IDX_PD_DIR:  rd_byte = dir_q[31:24];
      `PMCR_IDX_PD_OPT:  rd_byte = opt_q[31:24];
      `PMCR_IDX_PE_DATA: rd_byte = pin_read(dir_q[39:32], data_q[39:32], PIN_IN[39:32]);
      `PMCR_IDX_PE_DIR:  rd_byte = dir_q[39:32];
      `PMCR_IDX_PE_OPT:  rd_byte = opt_q[39:32];
      `PMCR_IDX_PF_DATA: rd_byte = pin_read(dir_q[47:40], data_q[47:40], PIN_IN[47:40]);
      `PMCR_IDX_PF_DIR:  rd_byte = dir_q[47:40];
      `PMCR_IDX_SENSE_CLK:
        rd_byte = {sense_a_q, clk_out_q, sense_d_q, pre_sel_q, pre_en_q};
      `PMCR_IDX_PWR_GATE:
        rd_byte = {3'h0, pwr_off_q} & `PMCR_PWR_MASK;
      `PMCR_IDX_HALT_PWM:
        rd_byte = {wdg_policy_q, 3'h0, sense_c_q, pulse1_q, pulse0_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read channel; data captured on the address handshake
  always @(posedge CLOCK) begin
    if (!RESETN) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h00000000;
      RRESP  <= `PMCR_RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RDATA  <= {24'h000000, rd_byte};
      RRESP  <= reg_hit(rd_idx) ? `PMCR_RESP_OKAY : `PMCR_RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pads: options on A, C, D, E; interrupts on A, C, D

  genvar p;
  generate
    for (p = 0; p < 6; p = p + 1) begin : g_port
      pmcr_pin_cfg #(
        .HAS_OPT ((p == 0 || p == 2 || p == 3 || p == 4) ? 1 : 0),
        .IRQ_CAP ((p == 0 || p == 2 || p == 3) ? 1 : 0)
      ) u_pin (
        .clk     (CLOCK),
        .rst_n   (RESETN),
        .latch   (data_q[8*p +: 8]),
        .dir     (dir_q[8*p +: 8]),
        .opt     (opt_q[8*p +: 8]),
        .pad_out (PIN_OUT[8*p +: 8]),
        .pad_oe  (PIN_OE[8*p +: 8]),
        .irq_en  (port_irq_en[8*p +: 8])
      );
    end
  endgenerate

  // Interrupt masks for the three groups, A, C, D order
  // Taken from the pad blocks so the capability mask lives in one place
  assign irq_en = {port_irq_en[31:24], port_irq_en[23:16],
                   port_irq_en[7:0]};

  ////////////////////////////////////////////////////////////////////
  // External interrupt sensitivity

  pmcr_irq_sense u_sense_a (
    .clk    (CLOCK),
    .rst_n  (RESETN),
    .pins   (PIN_IN[7:0]),
    .enable (irq_en[7:0]),
    .mode   (sense_a_q),
    .irq    (EXT_IRQ_A)
  );

  pmcr_irq_sense u_sense_c (
    .clk    (CLOCK),
    .rst_n  (RESETN),
    .pins   (PIN_IN[23:16]),
    .enable (irq_en[15:8]),
    .mode   (sense_c_q),
    .irq    (EXT_IRQ_C)
  );

  pmcr_irq_sense u_sense_d (
    .clk    (CLOCK),
    .rst_n  (RESETN),
    .pins   (PIN_IN[31:24]),
    .enable (irq_en[23:16]),
    .mode   (sense_d_q),
    .irq    (EXT_IRQ_D)
  );

  ////////////////////////////////////////////////////////////////////
  // Clock selection, gating, alternate functions and halt policy

  reg [15:0] khz_d;

  // CPU clock figure; coprocessor clock has no dependency here
  always @* begin
    if (!pre_en_q) begin
      khz_d = USB_MODE ? `PMCR_USB_DEFAULT_KHZ : `PMCR_SA_DEFAULT_KHZ;
    end else begin
      case ({USB_MODE, pre_sel_q})
        3'h0:    khz_d = `PMCR_SA_CODE0_KHZ;
        3'h2:    khz_d = `PMCR_SA_CODE2_KHZ;
        3'h1:    khz_d = `PMCR_SA_CODE1_KHZ;
        3'h3:    khz_d = `PMCR_SA_CODE3_KHZ;
        3'h4:    khz_d = `PMCR_USB_CODE0_KHZ;
        3'h6:    khz_d = `PMCR_USB_CODE2_KHZ;
        3'h5:    khz_d = `PMCR_USB_CODE1_KHZ;
        default: khz_d = `PMCR_USB_CODE3_KHZ;
      endcase
    end
  end

  // Registered control outputs; halt decisions follow HALT_EXEC one cycle later, for as long as it is held
  always @(posedge CLOCK) begin
    if (!RESETN) begin
      CPU_CLK_SEL       <= 3'h0;
      CPU_CLK_KHZ       <= `PMCR_SA_DEFAULT_KHZ;
      USB_BUF_ACCESS_EN <= 1'b1;
      PERIPH_OFF        <= 5'h00;
      CLOCK_OUT_EN      <= 1'b0;
      PULSE0_OUT_EN     <= 1'b0;
      PULSE1_OUT_EN     <= 1'b0;
      WDG_RESET_REQ     <= 1'b0;
      HALT_ENTER        <= 1'b0;
    end else begin
      CPU_CLK_SEL       <= {pre_en_q, pre_sel_q};
      CPU_CLK_KHZ       <= khz_d;
      // Stand-alone 6 MHz leaves no cycles for the USB buffer
      USB_BUF_ACCESS_EN <= !(!USB_MODE && pre_en_q && pre_sel_q == 2'h0);
      PERIPH_OFF        <= pwr_off_q;
      CLOCK_OUT_EN      <= clk_out_q;
      PULSE0_OUT_EN     <= pulse0_q;
      PULSE1_OUT_EN     <= pulse1_q;
      WDG_RESET_REQ     <= HALT_EXEC && WATCHDOG_ACTIVE && !wdg_policy_q && !USB_SUSPEND;
      HALT_ENTER        <= HALT_EXEC && !(WATCHDOG_ACTIVE && !wdg_policy_q && !USB_SUSPEND);
    end
  end

endmodule

/* File: test/pmcr_checker_asserts.sv */
// Checker for the register bank: bus handshakes, halt and clock outputs.
// Bound to pmcr_top; sees its ports only, one clock domain.
module pmcr_checker (
  input logic        CLOCK,
  input logic        RESETN,
  input logic        AWREADY,
  input logic        WREADY,
  input logic        BVALID,
  input logic        BREADY,
  input logic [1:0]  BRESP,
  input logic        ARVALID,
  input logic        ARREADY,
  input logic        RVALID,
  input logic        RREADY,
  input logic [31:0] RDATA,
  input logic        HALT_EXEC,
  input logic        WATCHDOG_ACTIVE,
  input logic        USB_SUSPEND,
  input logic        WDG_RESET_REQ,
  input logic        HALT_ENTER,
  input logic [2:0]  CPU_CLK_SEL,
  input logic        USB_BUF_ACCESS_EN
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // One domain, so clock and reset are given once
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  ////////////////////////////////////////////////////////////////////////////
  // Answers stand until taken; no new write taken while a response is pending
  bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read answer dropped early");
  read_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  write_block_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");
  read_upper_a: assert property (RVALID |-> RDATA[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  ////////////////////////////////////////////////////////////////////////////
  // Halt outcome follows its causes one cycle later
  suspend_halt_a: assert property (HALT_EXEC && WATCHDOG_ACTIVE && USB_SUSPEND
    |=> !WDG_RESET_REQ && HALT_ENTER)
    else $error("watchdog reset during suspend");
  reset_cause_a: assert property ($rose(WDG_RESET_REQ)
    |-> $past(HALT_EXEC && WATCHDOG_ACTIVE && !USB_SUSPEND))
    else $error("watchdog reset without cause");
  halt_cause_a: assert property (HALT_ENTER |-> $past(HALT_EXEC) && !WDG_RESET_REQ)
    else $error("halt entered without halt");
  buffer_block_a: assert property (!USB_BUF_ACCESS_EN |-> CPU_CLK_SEL == 3'h4)
    else $error("buffer blocked at wrong clock");

  ////////////////////////////////////////////////////////////////////////////
  // Main scenarios reached
  write_c: cover property (BVALID && BREADY);
  read_c: cover property (RVALID && RREADY);
  wdg_c: cover property (WDG_RESET_REQ);
  block_c: cover property (!USB_BUF_ACCESS_EN);
endmodule

/* File: test/testbench.sv */
// Self-checking bench for pmcr_top over AXI4-Lite register tasks.
// Assumes pmcr_consts.vh on the include path and the checker file compiled.
`include "pmcr_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0]  AWADDR, ARADDR;
  logic [2:0]  AWPROT, ARPROT, CPU_CLK_SEL;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  logic [47:0] PIN_IN, PIN_OUT, PIN_OE;
  logic [15:0] CPU_CLK_KHZ;
  logic [4:0]  PERIPH_OFF;
  logic [7:0]  d, e, o;
  logic        CLOCK, RESETN, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY;
  logic        RVALID, RREADY, IRQ_MASK_HIGH, IRQ_MASK_LOW, EXT_IRQ_A, EXT_IRQ_D, EXT_IRQ_C;
  logic        CLOCK_OUT_EN, PULSE0_OUT_EN, PULSE1_OUT_EN, USB_MODE, USB_BUF_ACCESS_EN;
  logic        HALT_EXEC, WATCHDOG_ACTIVE, USB_SUSPEND, WDG_RESET_REQ, HALT_ENTER, s;
  int          errors, cmp_count, n;
  logic [15:0] kz [10] = '{`PMCR_SA_DEFAULT_KHZ, `PMCR_SA_CODE0_KHZ, `PMCR_SA_CODE1_KHZ,
    `PMCR_SA_CODE2_KHZ, `PMCR_SA_CODE3_KHZ, `PMCR_USB_DEFAULT_KHZ, `PMCR_USB_CODE0_KHZ,
    `PMCR_USB_CODE1_KHZ, `PMCR_USB_CODE2_KHZ, `PMCR_USB_CODE3_KHZ};
  logic [6:0]  oi [3] = '{7'h02, 7'h0B, 7'h08};
  int          sh [3] = '{6, 3, 2};
  int          pb [3] = '{0, 24, 16};
  int          ic [5] = '{4, 1, 1, 2, 0};

  pmcr_top dut (.*);

  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 CLOCK = ~CLOCK;

  // Compare one result and count it
  task automatic chk(input string nm, input logic [47:0] ex, input logic [47:0] got);
    cmp_count++;
    if (got !== ex) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask

  // Decoded places answer OKAY, the rest SLVERR
  function automatic logic [1:0] ok(input logic [6:0] i);
    return ((i < 7'h11 && i != `PMCR_IDX_UNUSED) || i == `PMCR_IDX_SENSE_CLK ||
      i == `PMCR_IDX_PWR_GATE || i == `PMCR_IDX_HALT_PWM) ? `PMCR_RESP_OKAY : `PMCR_RESP_SLVERR;
  endfunction

  // Write one byte; address and data offered together, each released when taken
  task automatic wr(input logic [6:0] i, input logic [7:0] v);
    @(posedge CLOCK);
    AWADDR <= {i, 2'h0};
    WDATA <= {24'h0, v};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    forever begin
      @(posedge CLOCK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BVALID && BREADY) break;
    end
    BREADY <= 1'b0;
    chk("bresp", ok(i), BRESP);
  endtask

  // Read one byte and compare it with the expected value
  task automatic rd(input logic [6:0] i, input logic [7:0] ex);
    @(posedge CLOCK);
    ARADDR <= {i, 2'h0};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    forever begin
      @(posedge CLOCK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID && RREADY) break;
    end
    RREADY <= 1'b0;
    chk("rresp", ok(i), RRESP);
    chk("rdata", ex, RDATA[7:0]);
  endtask

  // Verdict; also reached by the watchdog
  task automatic summarize();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard, 20000 cycles, well beyond the under one thousand cycles needed
  initial begin
    #100us;
    errors++;
    summarize();
  end

  // Main sequence
  initial begin
    {CLOCK, RESETN, AWVALID, WVALID, BREADY, ARVALID, RREADY, HALT_EXEC} = '0;
    {IRQ_MASK_HIGH, IRQ_MASK_LOW, USB_MODE, WATCHDOG_ACTIVE, USB_SUSPEND} = '0;
    {AWADDR, ARADDR, AWPROT, ARPROT, WDATA} = '0;
    WSTRB = 4'h1;
    PIN_IN = 48'h0F1E2D3C4B5A;
    repeat (8) @(posedge CLOCK);
    RESETN <= 1'b1;
    @(posedge CLOCK);
    chk("khz", `PMCR_SA_DEFAULT_KHZ, CPU_CLK_KHZ);
    chk("oe", 48'h0, PIN_OE);
    for (int i = 0; i < 'h4D; i++) rd(7'(i), (i % 3 == 0 && i < 16) ? PIN_IN[i / 3 * 8 +: 8] : 8'h00);
    // Distinct byte per port place; data reads merge latch and pins
    for (int i = 0; i < 17; i++) wr(7'(i), 8'h5A ^ 8'(i));
    for (int i = 0; i < 17; i++) begin
      e = 8'h5A ^ 8'(i);
      d = 8'h5A ^ 8'(i + 1);
      o = (i == 3 || i == 15) ? 8'hFF : 8'h5A ^ 8'(i + 2);
      if (i % 3 == 0) begin
        rd(7'(i), (d & e) | (~d & PIN_IN[i / 3 * 8 +: 8]));
        chk("pout", e, PIN_OUT[i / 3 * 8 +: 8]);
        chk("poe", d & (o | ~e), PIN_OE[i / 3 * 8 +: 8]);
      end
      else rd(7'(i), i == 5 ? 8'h00 : e);
    end
    // Sensitivity writes refused below level 3; reserved bits stay zero
    wr(`PMCR_IDX_SENSE_CLK, 8'hFF);
    wr(`PMCR_IDX_PWR_GATE, 8'hFF);
    {IRQ_MASK_HIGH, IRQ_MASK_LOW} <= 2'h3;
    wr(`PMCR_IDX_HALT_PWM, 8'hFF);
    rd(`PMCR_IDX_SENSE_CLK, 8'h27);
    rd(`PMCR_IDX_PWR_GATE, 8'h1F);
    rd(`PMCR_IDX_HALT_PWM, 8'h8F);
    chk("outs", 4'hF, {CLOCK_OUT_EN, PULSE1_OUT_EN, PULSE0_OUT_EN, USB_BUF_ACCESS_EN});
    for (int b = 0; b < 5; b++) begin
      wr(`PMCR_IDX_PWR_GATE, 8'h01 << b);
      repeat (2) @(posedge CLOCK);
      chk("off", 5'h01 << b, PERIPH_OFF);
    end
    // Lane 0 strobe low leaves the register alone
    WSTRB <= 4'h0;
    wr(`PMCR_IDX_PWR_GATE, 8'h00);
    WSTRB <= 4'h1;
    rd(`PMCR_IDX_PWR_GATE, 8'h10);
    IRQ_MASK_HIGH <= 1'b1;
    IRQ_MASK_LOW <= 1'b1;
    wr(`PMCR_IDX_SENSE_CLK, 8'hFF);
    rd(`PMCR_IDX_SENSE_CLK, 8'hFF);
    IRQ_MASK_LOW <= 1'b0;
    wr(`PMCR_IDX_SENSE_CLK, 8'h00);
    rd(`PMCR_IDX_SENSE_CLK, 8'hD8);
    IRQ_MASK_LOW <= 1'b1;
    // Every prescaler setting in both operating modes
    for (int u = 0; u < 2; u++) begin
      USB_MODE <= u[0];
      for (int c = 0; c < 5; c++) begin
        wr(`PMCR_IDX_SENSE_CLK, c == 0 ? 8'h00 : 8'(c * 2 - 1));
        repeat (2) @(posedge CLOCK);
        chk("khz", kz[u * 5 + c], CPU_CLK_KHZ);
        chk("sel", c == 0 ? 3'h0 : 3'(c + 3), CPU_CLK_SEL);
        chk("usbbuf", !(u == 0 && c == 1), USB_BUF_ACCESS_EN);
      end
    end
    // Each group and sensitivity, then with the option bit off
    PIN_IN <= '1;
    for (int g = 0; g < 3; g++) begin
      wr(oi[g] - 7'h01, 8'h00);
      for (int m = 0; m < 5; m++) begin
        wr(oi[g], m == 4 ? 8'h00 : 8'h01);
        wr(g == 2 ? `PMCR_IDX_HALT_PWM : `PMCR_IDX_SENSE_CLK, 8'(m % 4) << sh[g]);
        n = 0;
        for (int k = 0; k < 10; k++) begin
          @(posedge CLOCK);
          s = g == 0 ? EXT_IRQ_A : g == 1 ? EXT_IRQ_D : EXT_IRQ_C;
          n += int'(s === 1'b1);
          if (k == 1 || k == 5) PIN_IN[pb[g]] <= (k == 5);
        end
        chk("irq", ic[m], n);
      end
    end
    // Halt outcome for every policy, watchdog and suspend combination
    for (int h = 0; h < 8; h++) begin
      WATCHDOG_ACTIVE <= h[0];
      USB_SUSPEND <= h[1];
      wr(`PMCR_IDX_HALT_PWM, {h[2], 7'h00});
      @(posedge CLOCK);
      HALT_EXEC <= 1'b1;
      @(posedge CLOCK);
      HALT_EXEC <= 1'b0;
      @(posedge CLOCK);
      s = h[0] & ~h[1] & ~h[2];
      chk("halt", {s, ~s}, {WDG_RESET_REQ, HALT_ENTER});
    end
    summarize();
  end
endmodule

bind pmcr_top pmcr_checker chk_u (.*);
